/* File: core/sscr_pkg.sv */
// Package: register map, defaults and sync timing constants for sscr block
package sscr_pkg;
	// Register offsets, serial address space
	localparam logic [7:0] OFS_SOFT_RESET = 8'h10;
	localparam logic [7:0] OFS_OUT_ENABLE = 8'h11;
	localparam logic [7:0] OFS_SYNC_CFG = 8'h12;
	localparam logic [7:0] OFS_SYNC_POL = 8'h13;
	localparam logic [7:0] OFS_CLK_HOLD = 8'h14;
	localparam logic [7:0] OFS_CORE_RUN = 8'h15;
	localparam logic [7:0] OFS_OSC_RUN = 8'h16;
	localparam logic [7:0] OFS_FACTORY = 8'h17;
	localparam logic [7:0] OFS_UPD_LINE = 8'h18;
	localparam logic [7:0] OFS_UPD_HOLD = 8'h19;
	localparam logic [7:0] OFS_GPO = 8'h1A;
	localparam logic [7:0] OFS_ROLE = 8'h20;
	localparam logic [7:0] OFS_FL_POL = 8'h21;
	localparam logic [7:0] OFS_EDGE_POS = 8'h22;
	// Serial word layout: address first, then data, LSB first
	localparam int ADDR_W = 8;
	localparam int DATA_W = 28;
	localparam int WORD_W = ADDR_W + DATA_W;
	// Field positions
	localparam int EXT_SEL_BIT = 0;
	localparam int TEST_A_LSB = 1;
	localparam int TEST_A_MSB = 7;
	localparam int SRC_LSB = 8;
	localparam int SRC_MSB = 9;
	localparam int TEST_B_MSB = 8;
	localparam int UPD_MSB = 11;
	localparam int LS_POS_MSB = 12;
	localparam int FS_POS_LSB = 13;
	localparam int FS_POS_MSB = 24;
	// Reset values
	localparam logic RST_EXT_SEL = 1'h1;
	localparam logic [1:0] RST_SRC = 2'h0;
	localparam logic [11:0] RST_UPD_LINE = 12'h000;
	localparam logic [24:0] RST_EDGE_POS = 25'h0000000;
	// Sync pin source selector
	typedef enum logic [1:0] {
		SRC_CLAMP = 2'h0,
		SRC_PREBLANK = 2'h1,
		SRC_GPO = 2'h2,
		SRC_SHUTTER = 2'h3
	} sscr_src_t;
	// Master timing frame, in pixel clocks and lines
	localparam logic [12:0] PIX_PER_LINE = 13'h0C80;
	localparam logic [11:0] LINES_PER_FIELD = 12'h20D;
	localparam logic [12:0] LS_WIDTH = 13'h0010;
	localparam logic [11:0] FS_WIDTH = 12'h003;
endpackage

/* File: core/sscr_if.sv */
// Interfaces: serial write port and sync timing link inside the block
`timescale 1ns/10ps
interface sscr_wr_if;
	logic wr_valid; // One-cycle pulse per complete serial word
	logic [7:0] wr_addr;
	logic [27:0] wr_data;
	modport rx (output wr_valid, output wr_addr, output wr_data);
	modport regs (input wr_valid, input wr_addr, input wr_data);
endinterface
interface sscr_tim_if;
	logic master; // 1 device drives frame/line sync
	logic fl_pol; // Active level of frame/line sync
	logic [12:0] ls_pos; // Line sync rising pixel
	logic [11:0] fs_pos; // Frame sync rising line
	logic run; // Counters advance
	logic resync; // External sync active: restart timing
	logic frame_edge; // Pulse at frame sync rise
	logic line_edge; // Pulse at line sync rise
	logic [11:0] line_cnt; // Lines since frame sync
	logic fs_act; // Generated frame sync active
	logic ls_act; // Generated line sync active
	modport regs (output master, output fl_pol, output ls_pos, output fs_pos,
		output run, output resync, input frame_edge, input line_edge,
		input line_cnt, input fs_act, input ls_act);
	modport gen (input master, input fl_pol, input ls_pos, input fs_pos,
		input run, input resync, output frame_edge, output line_edge,
		output line_cnt, output fs_act, output ls_act);
endinterface

/* File: core/sscr_serial_rx.sv */
// Three-wire serial receiver: shifts address and data, commits on load rise
`timescale 1ns/10ps
module sscr_serial_rx (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load_n,
	sscr_wr_if.rx wr
);
	typedef struct packed {
		logic [2:0] s1; // First sync stage, read only by s2
		logic [2:0] s2; // Second sync stage
		logic [2:0] prev; // Delayed s2 for edge detect
		logic [35:0] shift; // Incoming word, LSB first
		logic [5:0] cnt; // Bits taken, saturating
		logic valid;
		logic [7:0] addr;
		logic [27:0] data;
	} sscr_rx_t;
	sscr_rx_t st_ff, nxt_st;
	// Pins cross into core_clk; sample on resolved edges
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = {ser_load_n, ser_data, ser_clk};
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = st_ff.s2;
		nxt_st.valid = 1'b0;
		// Clock rise inside an active frame shifts one bit
		if (!st_ff.s2[2] && st_ff.s2[0] && !st_ff.prev[0]) begin
			nxt_st.shift = {st_ff.s2[1], st_ff.shift[35:1]};
			if (st_ff.cnt != 6'h3F) begin
				nxt_st.cnt = st_ff.cnt + 6'h01;
			end
		end
		// Load rise ends the frame; short or long words are dropped
		if (st_ff.s2[2] && !st_ff.prev[2]) begin
			nxt_st.cnt = 6'h00;
			if (st_ff.cnt == 6'(sscr_pkg::WORD_W)) begin
				nxt_st.valid = 1'b1;
				nxt_st.addr = st_ff.shift[7:0];
				nxt_st.data = st_ff.shift[35:8];
			end
		end
		// Idle line holds counter clear
		if (st_ff.s2[2] && st_ff.prev[2]) begin
			nxt_st.cnt = 6'h00;
		end
	end
	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign wr.wr_valid = st_ff.valid;
	assign wr.wr_addr = st_ff.addr;
	assign wr.wr_data = st_ff.data;
endmodule // sscr_serial_rx

/* File: core/sscr_sync_gen.sv */
// Frame/line sync generator (master) and sync edge tracker (slave)
`timescale 1ns/10ps
module sscr_sync_gen (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic fs_pin_i,
	input wire logic ls_pin_i,
	sscr_tim_if.gen tim
);
	typedef struct packed {
		logic [1:0] s1; // First sync stage of frame/line pins
		logic [1:0] s2;
		logic [12:0] pix; // Master pixel counter
		logic [11:0] line; // Master line counter
		logic fs_a; // Active-high frame sync, either role
		logic ls_a; // Active-high line sync, either role
		logic fs_d;
		logic ls_d;
		logic [11:0] lcnt; // Lines since last frame edge
	} sscr_gen_t;
	sscr_gen_t st_ff, nxt_st;
	logic [12:0] pix_off;
	logic [11:0] line_off;
	logic fs_edge;
	logic ls_edge;
	// Distance past programmed rise positions
	assign pix_off = st_ff.pix - tim.ls_pos;
	assign line_off = st_ff.line - tim.fs_pos;
	assign fs_edge = st_ff.fs_a && !st_ff.fs_d;
	assign ls_edge = st_ff.ls_a && !st_ff.ls_d;
	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = {fs_pin_i, ls_pin_i};
		nxt_st.s2 = st_ff.s1;
		nxt_st.fs_d = st_ff.fs_a;
		nxt_st.ls_d = st_ff.ls_a;
		if (tim.master) begin
			// Sync is gated by run, so suspend forces both syncs inactive
			if (tim.resync) begin
				nxt_st.pix = '0;
				nxt_st.line = '0;
			end else if (tim.run) begin
				if (st_ff.pix == sscr_pkg::PIX_PER_LINE - 13'h0001) begin
					nxt_st.pix = '0;
					nxt_st.line = (st_ff.line == sscr_pkg::LINES_PER_FIELD -
						12'h001) ? 12'h000 : st_ff.line + 12'h001;
				end else begin
					nxt_st.pix = st_ff.pix + 13'h0001;
				end
			end
			nxt_st.ls_a = tim.run && pix_off < sscr_pkg::LS_WIDTH;
			// One rise per field: from the line sync rise of the
			// programmed line to the same pixel FS_WIDTH lines on,
			// so the line count sees a single frame edge
			nxt_st.fs_a = tim.run && ((line_off != 12'h000 &&
				line_off < sscr_pkg::FS_WIDTH) ||
				(line_off == 12'h000 && st_ff.pix >= tim.ls_pos) ||
				(line_off == sscr_pkg::FS_WIDTH &&
				st_ff.pix < tim.ls_pos));
		end else begin
			// Host drives; fold polarity into active-high
			nxt_st.fs_a = st_ff.s2[1] ~^ tim.fl_pol;
			nxt_st.ls_a = st_ff.s2[0] ~^ tim.fl_pol;
		end
		// Field line count from sync edges, common to both roles
		if (fs_edge) begin
			nxt_st.lcnt = '0;
		end else if (ls_edge) begin
			nxt_st.lcnt = st_ff.lcnt + 12'h001;
		end
	end
	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign tim.frame_edge = fs_edge;
	assign tim.line_edge = ls_edge;
	assign tim.line_cnt = st_ff.lcnt;
	assign tim.fs_act = st_ff.fs_a;
	assign tim.ls_act = st_ff.ls_a;
endmodule // sscr_sync_gen

/* File: core/sscr_top.sv */
// System control and frame/line sync register bank with pin muxing
//
// Behaviour
// - Soft reset restores all registers, self-clears
// - Outputs inactive until enabled, then next frame
// - External sync pin input with selectable polarity
// - Otherwise pin drives selected internal signal
// - Clock hold suspends clocks during sync active
// - Timing core held in reset while run=0
// - Oscillator driver powered down while run=0
// - Update line picks transfer line in field
// - Update hold blocks pending register transfers
// - Pin drives general output, changes at frame
// - Role bit master/slave, polarity bit level
// - Master line sync rises at programmed pixel
// - Master frame sync rises at programmed line
`timescale 1ns/10ps
module sscr_top (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load_n,
	input wire logic sync_pin_i,
	output logic sync_pin_o,
	output logic sync_pin_oe,
	input wire logic fs_pin_i,
	output logic fs_pin_o,
	output logic fs_pin_oe,
	input wire logic ls_pin_i,
	output logic ls_pin_o,
	output logic ls_pin_oe,
	input wire logic black_clamp_pulse,
	input wire logic pre_blank_pulse,
	input wire logic shutter_test_out,
	output logic outputs_live,
	output logic clk_suspend,
	output logic timing_core_rst,
	output logic osc_power_down,
	output logic [11:0] field_line
);
	// Whole register bank plus pin state
	typedef struct packed {
		logic soft_reset_trigger; // One-cycle, self-clearing
		logic oe_pend; // Frame-updated output enable
		logic oe_act;
		logic live; // Outputs released at frame edge
		logic external_sync_select;
		logic [6:0] factory_test_a;
		logic [1:0] sync_pin_source_sel;
		logic sync_pin_polarity;
		logic clock_hold_on_sync;
		logic timing_core_run;
		logic oscillator_run;
		logic [8:0] factory_test_b;
		logic [11:0] upd_pend; // Frame-updated update line
		logic [11:0] upd_act;
		logic update_hold;
		logic gpo_pend;
		logic gpo_act;
		logic gpo_out; // Pin value, moves on frame edge
		logic master;
		logic frame_line_sync_polarity;
		logic [24:0] edge_pend;
		logic [24:0] edge_act;
		logic sp_s1; // Sync pin first stage
		logic sp_s2;
		logic sp_o;
		logic fs_o;
		logic ls_o;
	} sscr_state_t;

	sscr_state_t st_ff, nxt_st, dflt;
	sscr_wr_if wr ();
	sscr_tim_if tim ();
	logic ext_active; // External sync asserted, active-high
	logic upd_now; // Transfer pending frame-updated values
	logic pin_sel_val; // Internal signal routed to sync pin

	// Reset image of every register
	function automatic sscr_state_t reset_image();
		sscr_state_t r;
		r = '0;
		r.external_sync_select = sscr_pkg::RST_EXT_SEL;
		r.sync_pin_source_sel = sscr_pkg::RST_SRC;
		r.upd_pend = sscr_pkg::RST_UPD_LINE;
		r.upd_act = sscr_pkg::RST_UPD_LINE;
		r.edge_pend = sscr_pkg::RST_EDGE_POS;
		r.edge_act = sscr_pkg::RST_EDGE_POS;
		return r;
	endfunction

	// Active level with programmable polarity
	function automatic logic to_pin(input logic act, input logic pol);
		return act ~^ pol;
	endfunction

	assign dflt = reset_image();

	// Serial port receiver
	sscr_serial_rx u_rx (
		.core_clk(core_clk),
		.reset(reset),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_load_n(ser_load_n),
		.wr(wr.rx)
	);

	// Frame/line timing
	sscr_sync_gen u_gen (
		.core_clk(core_clk),
		.reset(reset),
		.fs_pin_i(fs_pin_i),
		.ls_pin_i(ls_pin_i),
		.tim(tim.gen)
	);

	// Sync pin as input only when external sync selected
	assign ext_active = st_ff.external_sync_select &&
		(st_ff.sp_s2 ~^ st_ff.sync_pin_polarity);

	// Transfer at chosen line unless held
	assign upd_now = tim.line_edge && !st_ff.update_hold &&
		(tim.line_cnt == st_ff.upd_act);

	// Timing link configuration; positions from active copies
	assign tim.master = st_ff.master;
	assign tim.fl_pol = st_ff.frame_line_sync_polarity;
	// Positions move only at the line sync edge of the update line
	assign tim.ls_pos = st_ff.edge_act[sscr_pkg::LS_POS_MSB:0];
	assign tim.fs_pos =
		st_ff.edge_act[sscr_pkg::FS_POS_MSB:sscr_pkg::FS_POS_LSB];
	// Core stops while in reset or suspended during sync
	assign tim.run = st_ff.timing_core_run && !clk_suspend;
	assign tim.resync = ext_active;

	// Source mux for sync pin when used as output
	always_comb begin
		unique case (sscr_pkg::sscr_src_t'(st_ff.sync_pin_source_sel))
			sscr_pkg::SRC_CLAMP: pin_sel_val = black_clamp_pulse;
			sscr_pkg::SRC_PREBLANK: pin_sel_val = pre_blank_pulse;
			sscr_pkg::SRC_GPO: pin_sel_val = st_ff.gpo_out;
			sscr_pkg::SRC_SHUTTER: pin_sel_val = shutter_test_out;
		endcase
	end

	// Next state: writes, transfers, pins
	always_comb begin
		nxt_st = st_ff;
		nxt_st.soft_reset_trigger = 1'b0;
		nxt_st.sp_s1 = sync_pin_i;
		nxt_st.sp_s2 = st_ff.sp_s1;

		// Immediate-update registers take the write at once
		if (wr.wr_valid) begin
			unique case (wr.wr_addr)
				sscr_pkg::OFS_SOFT_RESET:
					nxt_st.soft_reset_trigger = wr.wr_data[0];
				sscr_pkg::OFS_OUT_ENABLE: nxt_st.oe_pend = wr.wr_data[0];
				sscr_pkg::OFS_SYNC_CFG: begin
					nxt_st.external_sync_select =
						wr.wr_data[sscr_pkg::EXT_SEL_BIT];
					// Stored only; the host keeps these zero
					nxt_st.factory_test_a = wr.wr_data[
						sscr_pkg::TEST_A_MSB:sscr_pkg::TEST_A_LSB];
					nxt_st.sync_pin_source_sel =
						wr.wr_data[sscr_pkg::SRC_MSB:sscr_pkg::SRC_LSB];
				end
				sscr_pkg::OFS_SYNC_POL:
					nxt_st.sync_pin_polarity = wr.wr_data[0];
				sscr_pkg::OFS_CLK_HOLD:
					nxt_st.clock_hold_on_sync = wr.wr_data[0];
				sscr_pkg::OFS_CORE_RUN:
					nxt_st.timing_core_run = wr.wr_data[0];
				sscr_pkg::OFS_OSC_RUN: nxt_st.oscillator_run = wr.wr_data[0];
				sscr_pkg::OFS_FACTORY:
					nxt_st.factory_test_b =
						wr.wr_data[sscr_pkg::TEST_B_MSB:0];
				sscr_pkg::OFS_UPD_LINE:
					nxt_st.upd_pend = wr.wr_data[sscr_pkg::UPD_MSB:0];
				sscr_pkg::OFS_UPD_HOLD: nxt_st.update_hold = wr.wr_data[0];
				sscr_pkg::OFS_GPO: nxt_st.gpo_pend = wr.wr_data[0];
				sscr_pkg::OFS_ROLE: nxt_st.master = wr.wr_data[0];
				sscr_pkg::OFS_FL_POL:
					nxt_st.frame_line_sync_polarity = wr.wr_data[0];
				sscr_pkg::OFS_EDGE_POS:
					nxt_st.edge_pend = wr.wr_data[sscr_pkg::FS_POS_MSB:0];
				// Unmapped addresses are ignored
				default: nxt_st.soft_reset_trigger = 1'b0;
			endcase
		end

		// Frame-updated registers copy pending to active
		if (upd_now) begin
			nxt_st.oe_act = st_ff.oe_pend;
			nxt_st.upd_act = st_ff.upd_pend;
			nxt_st.gpo_act = st_ff.gpo_pend;
			nxt_st.edge_act = st_ff.edge_pend;
		end

		// Outputs go live only on a frame edge, drop at once
		if (!st_ff.oe_act) begin
			nxt_st.live = 1'b0;
		end else if (tim.frame_edge) begin
			nxt_st.live = 1'b1;
		end

		// General output value moves on the frame edge
		if (tim.frame_edge) begin
			nxt_st.gpo_out = st_ff.gpo_act;
		end

		// Pin drive, parked at inactive level while not live
		nxt_st.sp_o = st_ff.live ? pin_sel_val : 1'b0;
		nxt_st.fs_o = to_pin(st_ff.live && tim.fs_act,
			st_ff.frame_line_sync_polarity);
		nxt_st.ls_o = to_pin(st_ff.live && tim.ls_act,
			st_ff.frame_line_sync_polarity);

		// Soft reset wipes the bank in the cycle after the write
		if (st_ff.soft_reset_trigger) begin
			nxt_st = dflt;
			nxt_st.sp_s1 = sync_pin_i;
			nxt_st.sp_s2 = st_ff.sp_s1;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_ff <= reset_image();
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Pin enables follow configuration directly
	// Enables are not gated by live, so a pin never floats while
	// its role is output; only its level is parked
	assign sync_pin_oe = !st_ff.external_sync_select;
	assign sync_pin_o = st_ff.sp_o;
	assign fs_pin_oe = st_ff.master;
	assign ls_pin_oe = st_ff.master;
	assign fs_pin_o = st_ff.fs_o;
	assign ls_pin_o = st_ff.ls_o;
	assign outputs_live = st_ff.live;
	// Suspend only while hold enabled and sync active
	assign clk_suspend = st_ff.clock_hold_on_sync && ext_active;
	assign timing_core_rst = !st_ff.timing_core_run;
	assign osc_power_down = !st_ff.oscillator_run;
	assign field_line = tim.line_cnt;
endmodule // sscr_top

/* File: verification/sscr_top_sva.sv */
// Checker: port-level timing relations of the sync/system control bank
`timescale 1ns/10ps
module sscr_top_sva (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sync_pin_o,
	input wire logic sync_pin_oe,
	input wire logic fs_pin_oe,
	input wire logic ls_pin_oe,
	input wire logic outputs_live,
	input wire logic clk_suspend,
	input wire logic timing_core_rst,
	input wire logic osc_power_down,
	input wire logic [11:0] field_line
);
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	// Defaults seen at the first edge after release
	core_dflt_a: assert property ($fell(reset) |-> timing_core_rst)
		else $error("core not held after reset");
	osc_dflt_a: assert property ($fell(reset) |-> osc_power_down)
		else $error("oscillator not down after reset");
	ext_sync_dflt_a: assert property ($fell(reset) |-> !sync_pin_oe)
		else $error("sync pin driven after reset");
	live_dflt_a: assert property ($fell(reset) |-> !outputs_live)
		else $error("outputs live after reset");
	// Both frame and line pins follow one role bit
	role_pair_a: assert property (fs_pin_oe == ls_pin_oe)
		else $error("frame and line enables differ");
	// Pin idles low while outputs are not live
	pin_idle_a: assert property (!outputs_live[*2] |-> !sync_pin_o)
		else $error("sync pin active while not live");
	// Suspend only possible with the pin as input
	suspend_gate_a: assert property (sync_pin_oe[*2] |-> !clk_suspend)
		else $error("suspend while pin is output");
	// Going live happens at a frame edge, when line count restarts
	live_frame_a: assert property ($rose(outputs_live) |->
		field_line == 12'h000)
		else $error("outputs went live away from frame edge");
	// Line count steps by one or restarts at zero
	line_step_a: assert property ($changed(field_line) |->
		field_line == 12'($past(field_line) + 12'h001) ||
		field_line == 12'h000)
		else $error("line count jumped");
endmodule // sscr_top_sva
bind sscr_top sscr_top_sva sscr_top_sva_inst (.core_clk(core_clk),
	.reset(reset), .sync_pin_o(sync_pin_o), .sync_pin_oe(sync_pin_oe),
	.fs_pin_oe(fs_pin_oe), .ls_pin_oe(ls_pin_oe), .outputs_live(outputs_live),
	.clk_suspend(clk_suspend), .timing_core_rst(timing_core_rst),
	.osc_power_down(osc_power_down), .field_line(field_line));

/* File: verification/sscr_host_sync.sv */
// Host model: supplies frame/line sync to a slave device
`timescale 1ns/10ps
module sscr_host_sync (
	input wire logic core_clk,
	input wire logic drive_en,
	input wire logic pol,
	output logic fs_o,
	output logic ls_o
);
	// Short frames: 40 clocks a line, 4 lines a frame, keeps runs brief
	int pix = 0;
	int line = 0;
	// Pixel and line counters, free running
	always @(posedge core_clk) begin
		pix <= (pix == 39) ? 0 : pix + 1;
		if (pix == 39) begin
			line <= (line == 3) ? 0 : line + 1;
		end
	end
	// Active level from polarity; released pins toggle, never hold
	assign ls_o = drive_en ? ((pix < 4) ~^ pol) : pix[0];
	assign fs_o = drive_en ? ((line == 0 && pix < 4) ~^ pol) : pix[1];
endmodule // sscr_host_sync

/* File: verification/testbench.sv */
// Testbench: serial register writes and sync pin behaviour checks
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic ser_clk = 1'b0;
	logic ser_data = 1'b0;
	logic ser_load_n = 1'b1;
	logic sync_pin_i = 1'b1;
	logic clamp = 1'b1;
	logic preblank = 1'b0;
	logic shutter = 1'b1;
	logic host_en = 1'b1;
	logic host_fs, host_ls;
	logic sync_pin_o, sync_pin_oe, fs_pin_o, fs_pin_oe, ls_pin_o, ls_pin_oe;
	logic outputs_live, clk_suspend, timing_core_rst, osc_power_down;
	logic [11:0] field_line;
	int mismatches = 0;
	int samples_checked = 0;
	// Clock, 5 ns period
	always #2.5 core_clk = ~core_clk;
	// Sync pins resolve from whoever drives them
	wire fs_wire = fs_pin_oe ? fs_pin_o : host_fs;
	wire ls_wire = ls_pin_oe ? ls_pin_o : host_ls;
	sscr_host_sync sscr_host_sync_inst (.core_clk(core_clk),
		.drive_en(host_en), .pol(1'b0), .fs_o(host_fs), .ls_o(host_ls));
	sscr_top sscr_top_inst (.core_clk(core_clk), .reset(reset),
		.ser_clk(ser_clk), .ser_data(ser_data), .ser_load_n(ser_load_n),
		.sync_pin_i(sync_pin_i), .sync_pin_o(sync_pin_o),
		.sync_pin_oe(sync_pin_oe), .fs_pin_i(fs_wire), .fs_pin_o(fs_pin_o),
		.fs_pin_oe(fs_pin_oe), .ls_pin_i(ls_wire), .ls_pin_o(ls_pin_o),
		.ls_pin_oe(ls_pin_oe), .black_clamp_pulse(clamp),
		.pre_blank_pulse(preblank), .shutter_test_out(shutter),
		.outputs_live(outputs_live), .clk_suspend(clk_suspend),
		.timing_core_rst(timing_core_rst), .osc_power_down(osc_power_down),
		.field_line(field_line));
	// Advance n cycles, landing just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// One 36-bit word, address then data, LSB first
	task automatic wr(input logic [7:0] a, input logic [27:0] d);
		logic [35:0] w;
		w = {d, a};
		ser_load_n = 1'b0;
		for (int i = 0; i < 36; i++) begin
			ser_data = w[i];
			ser_clk = 1'b0;
			tick(3);
			ser_clk = 1'b1;
			tick(3);
		end
		ser_clk = 1'b0;
		ser_load_n = 1'b1;
		tick(8);
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Cycles between two active onsets of the line pin (active low)
	task automatic line_period(output int n);
		int k;
		k = 0;
		while (ls_pin_o !== 1'b1 && k < 20000) begin
			tick(1);
			k++;
		end
		while (ls_pin_o !== 1'b0 && k < 20000) begin
			tick(1);
			k++;
		end
		// Count through the pulse and the idle gap after it
		n = 0;
		while (ls_pin_o !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
		while (ls_pin_o !== 1'b0 && n < 20000) begin
			tick(1);
			n++;
		end
	endtask
	// Watchdog, well above the expected run length
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		int per;
		tick(10);
		reset = 1'b0;
		tick(2);
		chk("core_rst", timing_core_rst, 1);
		chk("osc_pd", osc_power_down, 1);
		chk("sync_oe", sync_pin_oe, 0);
		chk("fs_idle", fs_pin_o, 1);
		wr(sscr_pkg::OFS_CORE_RUN, 28'h0000001);
		wr(sscr_pkg::OFS_OSC_RUN, 28'h0000001);
		chk("core_rst", timing_core_rst, 0);
		chk("osc_pd", osc_power_down, 0);
		// Pending enable must wait while held
		wr(sscr_pkg::OFS_UPD_HOLD, 28'h0000001);
		wr(sscr_pkg::OFS_UPD_LINE, 28'h0000002);
		wr(sscr_pkg::OFS_OUT_ENABLE, 28'h0000001);
		tick(500);
		chk("live_held", outputs_live, 0);
		wr(sscr_pkg::OFS_UPD_HOLD, 28'h0000000);
		tick(500);
		chk("live", outputs_live, 1);
		// Pin as output, general value arrives at a frame edge
		wr(sscr_pkg::OFS_SYNC_CFG, 28'h0000200);
		chk("sync_oe", sync_pin_oe, 1);
		chk("gpo0", sync_pin_o, 0);
		wr(sscr_pkg::OFS_GPO, 28'h0000001);
		tick(500);
		chk("gpo1", sync_pin_o, 1);
		// Remaining sources: clamp=1, preblank=0, shutter=1
		for (int s = 0; s < 4; s++) begin
			if (s != 2) begin
				wr(sscr_pkg::OFS_SYNC_CFG, {18'h00000, 2'(s), 8'h00});
				chk("src", sync_pin_o, (s == 1) ? 0 : 1);
			end
		end
		// Clock hold follows the external pulse and its polarity
		wr(sscr_pkg::OFS_SYNC_CFG, 28'h0000001);
		wr(sscr_pkg::OFS_CLK_HOLD, 28'h0000001);
		sync_pin_i = 1'b0;
		tick(6);
		chk("susp_low", clk_suspend, 1);
		sync_pin_i = 1'b1;
		tick(6);
		chk("susp_idle", clk_suspend, 0);
		wr(sscr_pkg::OFS_SYNC_POL, 28'h0000001);
		chk("susp_high", clk_suspend, 1);
		wr(sscr_pkg::OFS_CLK_HOLD, 28'h0000000);
		chk("susp_off", clk_suspend, 0);
		sync_pin_i = 1'b0;
		// Master mode: line period from the package frame size
		wr(sscr_pkg::OFS_EDGE_POS, {3'h0, 12'h001, 13'h0064});
		wr(sscr_pkg::OFS_ROLE, 28'h0000001);
		// Host lets go only once the device drives both pins
		host_en = 1'b0;
		chk("fs_oe", fs_pin_oe, 1);
		line_period(per);
		line_period(per);
		chk("line_per", per, 32'(sscr_pkg::PIX_PER_LINE));
		// Frame sync rose at line 1; now at the line 3 onset
		chk("fs_act", fs_pin_o, 0);
		chk("fl_line", field_line, 12'h002);
		// Soft reset restores every default
		wr(sscr_pkg::OFS_SOFT_RESET, 28'h0000001);
		chk("sr_core", timing_core_rst, 1);
		chk("sr_osc", osc_power_down, 1);
		chk("sr_role", fs_pin_oe, 0);
		chk("sr_sync", sync_pin_oe, 0);
		chk("sr_live", outputs_live, 0);
		chk("sr_fs", fs_pin_o, 1);
		report_and_stop();
	end
endmodule // testbench
